/* File: shared/icsi_pkg.sv */
// Contract
// RQ1 - manual mode, pin select enabled: pin low picks first input, high second
// RQ2 - pin select disabled: register choice bit decides, pin level ignored; automatic mode follows the active input instead
// RQ3 - automatic mode: pin driven low for first input active, high for second
// RQ4 - both inputs in alarm, hold: indicator keeps last active input
// RQ5 - pin shows active input only while indicator output enable is 1
// RQ6 - indicator output enable 0: pin released to high impedance
// RQ7 - read-only status bit always mirrors active input
// RQ8 - output format field picks format; CMOS drives both pins in phase
// RQ9 - four PLL channels, each with its own pin, bits and status
package icsi_pkg;
  localparam int ICSI_NCH = 4;
  localparam logic [11:0] ICSI_OFF_CTRL = 12'h000;
  localparam logic [11:0] ICSI_OFF_STAT = 12'h004;
  localparam logic [11:0] ICSI_OFF_FMT = 12'h008;
  // control byte per channel: bit positions
  localparam int ICSI_B_AUTO = 0;
  localparam int ICSI_B_PINSEL = 1;
  localparam int ICSI_B_REGCH = 2;
  localparam int ICSI_B_IND_OE = 3;
  localparam int ICSI_CTRL_W = 8;
  localparam logic [31:0] ICSI_CTRL_RST = 32'h0000_0000;
  localparam logic [31:0] ICSI_FMT_RST = 32'h0000_0000;
  // status byte per channel
  localparam int ICSI_S_ACTIVE = 0;
  localparam int ICSI_S_HOLD = 1;
  localparam int ICSI_S_SEL = 2;
  typedef enum logic [1:0] {
    ICSI_FMT_PECL = 2'h0,
    ICSI_FMT_LVDS = 2'h1,
    ICSI_FMT_CML = 2'h2,
    ICSI_FMT_CMOS = 2'h3
  } icsi_fmt_t;
endpackage : icsi_pkg

/* File: shared/icsi_ch_if.sv */
`timescale 1ns/1ps
interface icsi_ch_if;
  logic auto_mode;
  logic pin_select_enable;
  logic register_input_choice;
  logic indicator_output_enable;
  logic [1:0] output_format_field;
  logic active_input_indicator;
  logic holding;
  logic chosen;
  modport ctl (output auto_mode, pin_select_enable, register_input_choice,
               indicator_output_enable, output_format_field,
               input active_input_indicator, holding, chosen);
  modport ch (input auto_mode, pin_select_enable, register_input_choice,
              indicator_output_enable, output_format_field,
              output active_input_indicator, holding, chosen);
endinterface : icsi_ch_if

/* File: hdl/icsi_channel.sv */
`timescale 1ns/1ps
module icsi_channel import icsi_pkg::*; (
  input wire logic clk_i,
  input wire logic rst_i,
  icsi_ch_if.ch cfg,
  input wire logic pin_in_i,
  input wire logic alarm1_i,
  input wire logic alarm2_i,
  input wire logic ref1_i,
  input wire logic ref2_i,
  output logic pin_out_o,
  output logic pin_oe_o,
  output logic sel_o,
  output logic [1:0] out_p_o,
  output logic [1:0] out_n_o
);
  logic pin_s1, pin_s2, active, next_active, sel, next_sel;
  logic po, next_po, poe, next_poe;
  logic [1:0] op, on, next_op, next_on;
  logic ref_clk;

  always_comb begin
    next_active = active;
    if (!alarm1_i && !alarm2_i) begin
      if (alarm1_i == alarm2_i && !active) next_active = active;
    end
    if (!active && alarm1_i && !alarm2_i) next_active = 1'b1;
    if (active && alarm2_i && !alarm1_i) next_active = 1'b0;
    // both in alarm: hold keeps last active input, see RQ4
    if (cfg.auto_mode) begin
      next_sel = next_active;
    end else if (cfg.pin_select_enable) begin
      next_sel = pin_s2; // see RQ1
    end else begin
      next_sel = cfg.register_input_choice; // see RQ2
    end
    if (!cfg.auto_mode) next_active = next_sel;
    next_poe = cfg.auto_mode && cfg.indicator_output_enable; // see RQ5, RQ6
    next_po = next_poe ? active : 1'b0; // see RQ3
    ref_clk = sel ? ref2_i : ref1_i;
    next_op = {2{ref_clk}};
    // CMOS: both pins in phase; differential: complement, see RQ8
    next_on = (cfg.output_format_field == ICSI_FMT_CMOS) ? {2{ref_clk}} : {2{~ref_clk}};
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pin_s1 <= 1'b0;
      pin_s2 <= 1'b0;
      active <= 1'b0;
      sel <= 1'b0;
      po <= 1'b0;
      poe <= 1'b0;
      op <= 2'h0;
      on <= 2'h0;
    end else begin
      pin_s1 <= pin_in_i;
      pin_s2 <= pin_s1;
      active <= next_active;
      sel <= next_sel;
      po <= next_po;
      poe <= next_poe;
      op <= next_op;
      on <= next_on;
    end
  end

  assign cfg.active_input_indicator = active; // see RQ7
  assign cfg.holding = cfg.auto_mode && alarm1_i && alarm2_i;
  assign cfg.chosen = sel;
  assign pin_out_o = po;
  assign pin_oe_o = poe;
  assign sel_o = sel;
  assign out_p_o = op;
  assign out_n_o = on;

  AST_OE_ONLY_AUTO: assert property (@(posedge clk_i) disable iff (rst_i) // see RQ5
    pin_oe_o |-> $past(cfg.auto_mode && cfg.indicator_output_enable))
    else $error("pin driven without enable");
  AST_RELEASE: assert property (@(posedge clk_i) disable iff (rst_i) // see RQ6
    !cfg.indicator_output_enable ##1 !cfg.indicator_output_enable |-> !pin_oe_o)
    else $error("pin not released");
  AST_SHOWS_ACTIVE: assert property (@(posedge clk_i) disable iff (rst_i) // see RQ3
    pin_oe_o |-> pin_out_o == $past(active))
    else $error("pin level differs from active input");
  AST_PIN_SEL: assert property (@(posedge clk_i) disable iff (rst_i) // see RQ1
    (!cfg.auto_mode && cfg.pin_select_enable) ##1 (!cfg.auto_mode && cfg.pin_select_enable)
    |-> sel == $past(pin_s2))
    else $error("pin choice not taken");
  AST_REG_SEL: assert property (@(posedge clk_i) disable iff (rst_i) // see RQ2
    $past(!cfg.auto_mode && !cfg.pin_select_enable) |-> sel == $past(cfg.register_input_choice))
    else $error("register choice not taken");
  sequence s_hold2;
    cfg.auto_mode && alarm1_i && alarm2_i ##1 cfg.auto_mode && alarm1_i && alarm2_i;
  endsequence
  AST_HOLD_KEEP: assert property (@(posedge clk_i) disable iff (rst_i) // see RQ4
    s_hold2 |-> $stable(active))
    else $error("indicator moved in hold");
  AST_CMOS_PHASE: assert property (@(posedge clk_i) disable iff (rst_i) // see RQ8
    $past(cfg.output_format_field == ICSI_FMT_CMOS) |-> out_p_o == out_n_o)
    else $error("cmos pins not in phase");
  // both pins leave reset low, so the pair is complementary only from the next cycle on
  AST_DIFF: assert property (@(posedge clk_i) disable iff (rst_i) // see RQ8
    !$past(rst_i) && $past(cfg.output_format_field != ICSI_FMT_CMOS) |-> out_p_o == ~out_n_o)
    else $error("differential pair not complementary");
endmodule : icsi_channel

/* File: hdl/icsi_top.sv */
// The register offsets and the AHB-Lite slave port were chosen for this implementation.
`timescale 1ns/1ps
module icsi_top import icsi_pkg::*; #(
  parameter int NCH = ICSI_NCH
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic hsel_i,
  input wire logic [11:0] haddr_i,
  input wire logic [1:0] htrans_i,
  input wire logic hwrite_i,
  input wire logic [2:0] hsize_i,
  input wire logic [31:0] hwdata_i,
  input wire logic hready_i,
  output logic [31:0] hrdata_o,
  output logic hreadyout_o,
  output logic hresp_o,
  input wire logic [NCH-1:0] select_or_active_pin_i,
  output logic [NCH-1:0] select_or_active_pin_o,
  output logic [NCH-1:0] select_or_active_pin_oe_o,
  input wire logic [NCH-1:0] alarm1_i,
  input wire logic [NCH-1:0] alarm2_i,
  input wire logic [NCH-1:0] first_reference_input_i,
  input wire logic [NCH-1:0] second_reference_input_i,
  output logic [NCH-1:0] chosen_input_o,
  output logic [2*NCH-1:0] out_p_o,
  output logic [2*NCH-1:0] out_n_o
);
  logic [31:0] ctrl, next_ctrl, fmt, next_fmt, rdata, next_rdata, stat;
  logic wr_pend, next_wr_pend;
  logic [11:0] wr_addr, next_wr_addr;
  logic [NCH-1:0] al1_s1, al1_s2, al2_s1, al2_s2;
  logic [NCH-1:0] rf1_s1, rf1_s2, rf2_s1, rf2_s2;

  // alarms and reference levels come from outside this clock, so they are synchronised
  // first; the reference path pays two extra cycles of latency for that
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      al1_s1 <= '0;
      al1_s2 <= '0;
      al2_s1 <= '0;
      al2_s2 <= '0;
      rf1_s1 <= '0;
      rf1_s2 <= '0;
      rf2_s1 <= '0;
      rf2_s2 <= '0;
    end else begin
      al1_s1 <= alarm1_i;
      al1_s2 <= al1_s1;
      al2_s1 <= alarm2_i;
      al2_s2 <= al2_s1;
      rf1_s1 <= first_reference_input_i;
      rf1_s2 <= rf1_s1;
      rf2_s1 <= second_reference_input_i;
      rf2_s2 <= rf2_s1;
    end
  end

  // one independent channel per PLL, see RQ9
  for (genvar g = 0; g < NCH; g++) begin : g_ch
    icsi_ch_if cif ();
    logic [ICSI_CTRL_W-1:0] sbyte;
    assign cif.auto_mode = ctrl[g*ICSI_CTRL_W + ICSI_B_AUTO];
    assign cif.pin_select_enable = ctrl[g*ICSI_CTRL_W + ICSI_B_PINSEL];
    assign cif.register_input_choice = ctrl[g*ICSI_CTRL_W + ICSI_B_REGCH];
    assign cif.indicator_output_enable = ctrl[g*ICSI_CTRL_W + ICSI_B_IND_OE];
    assign cif.output_format_field = fmt[g*ICSI_CTRL_W +: 2];
    // each channel owns its own status byte, so one driver per slice
    always_comb begin
      sbyte = '0;
      sbyte[ICSI_S_ACTIVE] = cif.active_input_indicator; // see RQ7
      sbyte[ICSI_S_HOLD] = cif.holding;
      sbyte[ICSI_S_SEL] = cif.chosen;
    end
    assign stat[g*ICSI_CTRL_W +: ICSI_CTRL_W] = sbyte;
    icsi_channel u_ch (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .cfg(cif.ch),
      .pin_in_i(select_or_active_pin_i[g]),
      .alarm1_i(al1_s2[g]),
      .alarm2_i(al2_s2[g]),
      .ref1_i(rf1_s2[g]),
      .ref2_i(rf2_s2[g]),
      .pin_out_o(select_or_active_pin_o[g]),
      .pin_oe_o(select_or_active_pin_oe_o[g]),
      .sel_o(chosen_input_o[g]),
      .out_p_o(out_p_o[2*g +: 2]),
      .out_n_o(out_n_o[2*g +: 2])
    );
  end

  // zero wait state slave: write lands in the data phase, read data registered
  always_comb begin
    next_ctrl = ctrl;
    next_fmt = fmt;
    next_rdata = rdata;
    next_wr_pend = 1'b0;
    next_wr_addr = wr_addr;
    if (wr_pend) begin
      if (wr_addr == ICSI_OFF_CTRL) next_ctrl = hwdata_i;
      if (wr_addr == ICSI_OFF_FMT) next_fmt = hwdata_i;
    end
    if (hsel_i && hready_i && htrans_i[1]) begin
      next_wr_pend = hwrite_i;
      next_wr_addr = haddr_i;
      unique case (haddr_i)
        ICSI_OFF_CTRL: next_rdata = next_ctrl;
        ICSI_OFF_STAT: next_rdata = stat;
        ICSI_OFF_FMT: next_rdata = next_fmt;
        default: next_rdata = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl <= ICSI_CTRL_RST;
      fmt <= ICSI_FMT_RST;
      rdata <= 32'h0000_0000;
      wr_pend <= 1'b0;
      wr_addr <= 12'h000;
    end else begin
      ctrl <= next_ctrl;
      fmt <= next_fmt;
      rdata <= next_rdata;
      wr_pend <= next_wr_pend;
      wr_addr <= next_wr_addr;
    end
  end

  assign hrdata_o = rdata;
  assign hreadyout_o = 1'b1;
  assign hresp_o = 1'b0;
endmodule : icsi_top

/* File: tb/icsi_board.sv */
`timescale 1ns/1ps
// board side of the shared pins: a released, undriven pin flips each cycle
// so a stale level can never pass for a driven one
module icsi_board #(
  parameter int N = 4
) (
  input wire logic clk_i,
  input wire logic [N-1:0] dev_out_i,
  input wire logic [N-1:0] dev_oe_i,
  input wire logic [N-1:0] drv_en_i,
  input wire logic [N-1:0] drv_val_i,
  output logic [N-1:0] pin_o
);
  // starts low so an undriven pin never reads as unknown
  logic [N-1:0] last = '0;
  always_ff @(posedge clk_i) begin
    last <= pin_o;
  end
  always_comb begin
    for (int g = 0; g < N; g++) begin
      pin_o[g] = dev_oe_i[g] ? dev_out_i[g] : (drv_en_i[g] ? drv_val_i[g] : ~last[g]);
    end
  end
endmodule : icsi_board

/* File: tb/tb.sv */
`timescale 1ns/1ps
module tb;
  import icsi_pkg::*;
  logic clk_i = 0, rst_i = 1, hsel = 0, hwrite = 0, hready, hresp;
  logic [11:0] haddr = 0;
  logic [1:0] htrans = 0;
  logic [31:0] hwdata = 0, hrdata, r, v, w, e, lf = 32'h0001_70E8;
  logic [3:0] p_i, p_o, p_oe, a1 = 0, a2 = 0, r1 = 0, r2 = 0, ch, de = 0, dv = 0, act, s;
  logic [7:0] op, on, ep;
  int failures = 0, n_compared = 0, cyc = 0;
  always #4 clk_i = ~clk_i;
  icsi_top DUT(.clk_i(clk_i), .rst_i(rst_i), .hsel_i(hsel), .haddr_i(haddr),
    .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(3'h2), .hwdata_i(hwdata),
    .hready_i(hready), .hrdata_o(hrdata), .hreadyout_o(hready), .hresp_o(hresp),
    .select_or_active_pin_i(p_i), .select_or_active_pin_o(p_o),
    .select_or_active_pin_oe_o(p_oe), .alarm1_i(a1), .alarm2_i(a2),
    .first_reference_input_i(r1), .second_reference_input_i(r2),
    .chosen_input_o(ch), .out_p_o(op), .out_n_o(on));
  icsi_board BRD(.clk_i(clk_i), .dev_out_i(p_o), .dev_oe_i(p_oe), .drv_en_i(de),
    .drv_val_i(dv), .pin_o(p_i));
  function automatic logic [31:0] lfsr();
    lf = {lf[30:0], lf[31] ^ lf[21] ^ lf[1] ^ lf[0]};
    return lf;
  endfunction : lfsr
  task automatic chk(input logic [31:0] g, input logic [31:0] x, input string m);
    n_compared++;
    if (g !== x) begin
      failures++;
      $display("wrong value at %0t: %s got %h expected %h", $time, m, g, x);
    end
  endtask : chk
  task automatic bus(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk_i);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= 2'h2;
    hwrite <= wr;
    do @(posedge clk_i); while (hready !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clk_i); while (hready !== 1'b1);
    r = hrdata;
    chk(hresp, 32'h0000_0000, "response");
  endtask : bus
  task automatic wt(input int n);
    repeat (n) @(posedge clk_i);
  endtask : wt
  task automatic end_sim();
    $display("compared %0d, failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : end_sim
  // ceiling well above the few hundred cycles the sequence needs
  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 4000) begin
      failures++;
      end_sim();
    end
  end
  initial begin
    wt(3); rst_i <= 1'b0; wt(1);
    chk(p_oe, 0, "oe after reset");
    bus(0, ICSI_OFF_CTRL, 0); chk(r, ICSI_CTRL_RST, "ctrl reset");
    bus(0, ICSI_OFF_FMT, 0); chk(r, ICSI_FMT_RST, "fmt reset");
    bus(1, 12'h00C, 32'hFFFF_FFFF); bus(0, 12'h00C, 0); chk(r, 0, "unmapped");
    $display("test registers done");
    // register choice with pin forced the other way, then pin choice
    for (int k = 0; k < 6; k++) begin
      v = lfsr(); w = 0; de <= 4'hF;
      for (int g = 0; g < 4; g++) begin
        w[8*g+ICSI_B_REGCH] = (k < 3) ? v[g] : ~v[g];
        w[8*g+ICSI_B_PINSEL] = (k >= 3);
      end
      dv <= (k < 3) ? ~v[3:0] : v[3:0];
      bus(1, ICSI_OFF_CTRL, w); bus(0, ICSI_OFF_CTRL, 0); chk(r, w, "ctrl readback");
      wt(5); chk(ch, v[3:0], "chosen input");
      chk(p_oe, 0, "manual oe");
    end
    $display("test manual select done");
    for (int i = 0; i < 4; i++) begin
      v = lfsr(); w = 0; e = 0;
      for (int g = 0; g < 4; g++) begin
        w[8*g+ICSI_B_REGCH] = v[g];
        e[8*g+:2] = 2'((g + i) % 4);
      end
      bus(1, ICSI_OFF_CTRL, w); bus(1, ICSI_OFF_FMT, e);
      v = lfsr(); r1 <= v[3:0]; r2 <= v[7:4]; wt(4);
      for (int g = 0; g < 4; g++) begin
        s[g] = w[8*g+ICSI_B_REGCH] ? v[4+g] : v[g];
        ep[2*g+:2] = {2{s[g]}};
      end
      chk(op, ep, "out p");
      for (int g = 0; g < 4; g++) begin
        if (e[8*g+:2] != ICSI_FMT_CMOS) ep[2*g+:2] = ~ep[2*g+:2];
      end
      chk(on, ep, "out n");
    end
    $display("test formats done");
    bus(1, ICSI_OFF_CTRL, 0); wt(5); act = 0; de <= 4'h0;
    bus(1, ICSI_OFF_CTRL, 32'h0909_0909);
    for (int k = 0; k < 8; k++) begin
      v = lfsr(); a1 <= v[3:0]; a2 <= v[7:4]; e = 0;
      for (int g = 0; g < 4; g++) begin
        if (v[g] && !v[4+g]) act[g] = 1'b1;
        else if (v[4+g] && !v[g]) act[g] = 1'b0;
        e[8*g+ICSI_S_ACTIVE] = act[g];
        e[8*g+ICSI_S_HOLD] = v[g] & v[4+g];
      end
      wt(8); chk(p_o, act, "indicator");
      chk(p_oe, 4'hF, "oe on");
      bus(0, ICSI_OFF_STAT, 0); chk(r & 32'h0303_0303, e, "status");
    end
    bus(1, ICSI_OFF_CTRL, 32'h0101_0101); wt(4);
    chk(p_oe, 0, "oe off");
    bus(0, ICSI_OFF_STAT, 0); chk(r & 32'h0303_0303, e, "status oe off");
    $display("test automatic mode done");
    end_sim();
  end
endmodule : tb
